/* bench/tb_top.sv */
`timescale 1ns/10ps
module tb_top;
   import timers_pkg::*;
   localparam int WD_N = 8;
   logic i_clk;
   logic i_resetn;
   logic slow_pin;
   logic fast_pin;
   logic wd_clr;
   logic irq_a;
   logic irq_b;
   logic wd_rst;
   axil_req_type req;
   axil_rsp_type rsp;
   int err_count;
   int tests_run;
   int wd_seen = 0;
   int wd_base;

   // Short watchdog count keeps the overflow scenario brief
   dual_reload_timers_watchdog #(.WATCHDOG_BUILD_OPTION(1), .WATCHDOG_PULSES(WD_N)) dut (
      .i_clk(i_clk),
      .i_resetn(i_resetn),
      .i_axil(req),
      .o_axil(rsp),
      .i_slow_clock(slow_pin),
      .i_fast_clock(fast_pin),
      .i_watchdog_clear_instruction(wd_clr),
      .o_timer_a_irq(irq_a),
      .o_timer_b_irq(irq_b),
      .o_watchdog_reset(wd_rst)
   );

   always #25 i_clk = ~i_clk;

   always @(posedge i_clk) begin
      if (wd_rst === 1'b1) wd_seen <= wd_seen + 1;
   end

   ////////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("Checks run: %0d, mismatches: %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask : give_verdict

   task check(input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask : check

   task wr(input logic [5:0] idx, input logic [7:0] d);
      int n;
      @(posedge i_clk);
      req.awvalid <= 1'b1;
      req.awaddr <= {idx, 2'b00};
      req.wvalid <= 1'b1;
      req.wdata <= {24'h000000, d};
      req.wstrb <= 4'hf;
      req.bready <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
         if (req.awvalid && rsp.awready) req.awvalid <= 1'b0;
         if (req.wvalid && rsp.wready) req.wvalid <= 1'b0;
      end while (rsp.bvalid !== 1'b1 && n < 100);
      req.bready <= 1'b0;
      check({31'h0, rsp.bvalid}, 32'h1);
      check({30'h0, rsp.bresp}, {30'h0, RESP_OKAY});
   endtask : wr

   task rd(input logic [5:0] idx, input logic [31:0] exp, input logic [1:0] rexp);
      int n;
      @(posedge i_clk);
      req.arvalid <= 1'b1;
      req.araddr <= {idx, 2'b00};
      req.rready <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
         if (req.arvalid && rsp.arready) req.arvalid <= 1'b0;
      end while (rsp.rvalid !== 1'b1 && n < 100);
      req.rready <= 1'b0;
      check(rsp.rdata, exp);
      check({30'h0, rsp.rresp}, {30'h0, rexp});
   endtask : rd

   // Each pin level is held at least 3 cycles so the synchroniser sees every edge
   task pulses(input logic fast, input int n);
      repeat (n) begin
         @(posedge i_clk);
         if (fast) fast_pin <= 1'b1;
         else slow_pin <= 1'b1;
         repeat (3) @(posedge i_clk);
         fast_pin <= 1'b0;
         slow_pin <= 1'b0;
         repeat (3) @(posedge i_clk);
      end
      repeat (4) @(posedge i_clk);
   endtask : pulses

   task wd_clear;
      @(posedge i_clk);
      wd_clr <= 1'b1;
      @(posedge i_clk);
      wd_clr <= 1'b0;
   endtask : wd_clear

   task do_reset;
      @(posedge i_clk);
      i_resetn <= 1'b0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_clk);
   endtask : do_reset

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(20000 * 50);
      err_count++;
      give_verdict();
   end

   initial begin
      i_clk = 1'b0;
      i_resetn = 1'b0;
      req = '0;
      slow_pin = 1'b0;
      fast_pin = 1'b0;
      wd_clr = 1'b0;
      err_count = 0;
      tests_run = 0;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (2) @(posedge i_clk);
      rd(IDX_INTERRUPT_ENABLE, 32'h0, RESP_OKAY);
      rd(IDX_OPERATING_CONTROL, 32'h0, RESP_OKAY);
      rd(IDX_TIMER_B_COUNT, 32'h0, RESP_OKAY);
      rd(6'h07, 32'h0, RESP_SLVERR);
      wr(IDX_INTERRUPT_ENABLE, 8'hff);
      rd(IDX_INTERRUPT_ENABLE, 32'h6, RESP_OKAY);
      wr(IDX_OPERATING_CONTROL, 8'hf3);
      rd(IDX_OPERATING_CONTROL, 32'h0, RESP_OKAY);
      wr(IDX_INTERRUPT_ENABLE, 8'h00);
      // Timer B from the fast pin: three pulses always give two ticks
      wr(IDX_TIMER_B_RELOAD_LOW, 8'h05);
      wr(IDX_TIMER_B_RELOAD_HIGH, 8'h00);
      rd(IDX_TIMER_B_RELOAD_LOW, 32'h0, RESP_OKAY);
      wr(IDX_OPERATING_CONTROL, 8'h08);
      pulses(1'b1, 3);
      rd(IDX_TIMER_B_COUNT, 32'h4, RESP_OKAY);
      check({31'h0, irq_b}, 32'h0);
      wr(IDX_INTERRUPT_ENABLE, 8'h02);
      pulses(1'b1, 6);
      rd(IDX_TIMER_B_COUNT, 32'h0, RESP_OKAY);
      check({31'h0, irq_b}, 32'h0);
      pulses(1'b1, 3);
      rd(IDX_TIMER_B_COUNT, 32'h4, RESP_OKAY);
      check({31'h0, irq_b}, 32'h1);
      wr(IDX_OPERATING_CONTROL, 8'h00);
      // Timer A from the slow pin, then the fast pin in fast mode; the watchdog is fed before each slow batch
      // reload written before timer A runs
      wr(IDX_TIMER_A_RELOAD_LOW, 8'h03);
      wr(IDX_TIMER_A_RELOAD_HIGH, 8'h00);
      wr(IDX_OPERATING_CONTROL, 8'h04);
      wd_clear();
      pulses(1'b0, 1);
      rd(IDX_TIMER_A_COUNT, 32'h3, RESP_OKAY);
      check({31'h0, irq_a}, 32'h0);
      wr(IDX_INTERRUPT_ENABLE, 8'h04);
      wr(IDX_TIMER_A_RELOAD_HIGH, 8'h01);
      wd_clear();
      pulses(1'b0, 3);
      rd(IDX_TIMER_A_COUNT, 32'h0, RESP_OKAY);
      check({31'h0, irq_a}, 32'h0);
      wd_clear();
      pulses(1'b0, 1);
      rd(IDX_TIMER_A_COUNT, 32'h103, RESP_OKAY);
      check({31'h0, irq_a}, 32'h1);
      wr(IDX_IRQ_PENDING, 8'h04);
      @(posedge i_clk);
      check({31'h0, irq_a}, 32'h0);
      wr(IDX_OPERATING_CONTROL, 8'h00);
      wd_clear();
      pulses(1'b0, 1);
      rd(IDX_TIMER_A_COUNT, 32'h103, RESP_OKAY);
      wr(IDX_CLOCK_MODE, 8'h01);
      wr(IDX_OPERATING_CONTROL, 8'h04);
      pulses(1'b1, 1);
      rd(IDX_TIMER_A_COUNT, 32'h102, RESP_OKAY);
      // Sleep halts the shared source, so neither counter may move
      wr(IDX_CLOCK_MODE, 8'h04);
      wd_base = wd_seen;
      pulses(1'b0, 8);
      pulses(1'b1, 1);
      rd(IDX_TIMER_A_COUNT, 32'h102, RESP_OKAY);
      check(wd_seen - wd_base, 32'h0);
      do_reset();
      rd(IDX_TIMER_A_COUNT, 32'h0, RESP_OKAY);
      rd(IDX_OPERATING_CONTROL, 32'h0, RESP_OKAY);
      // Watchdog overflow after WD_N pulses, restarted by a clear
      wd_base = wd_seen;
      wd_clear();
      pulses(1'b0, WD_N - 1);
      check(wd_seen - wd_base, 32'h0);
      wd_clear();
      pulses(1'b0, WD_N - 1);
      check(wd_seen - wd_base, 32'h0);
      pulses(1'b0, 1);
      check(wd_seen - wd_base, 32'h1);
      // Idle stops the system clock only; slow mode feeds both timers
      wd_clear();
      wr(IDX_TIMER_A_RELOAD_LOW, 8'h02);
      wr(IDX_TIMER_B_RELOAD_LOW, 8'h09);
      wr(IDX_CLOCK_MODE, 8'h03);
      wr(IDX_OPERATING_CONTROL, 8'h0c);
      pulses(1'b0, 1);
      rd(IDX_TIMER_A_COUNT, 32'h2, RESP_OKAY);
      rd(IDX_TIMER_B_COUNT, 32'h0, RESP_OKAY);
      wr(IDX_CLOCK_MODE, 8'h02);
      pulses(1'b0, 3);
      rd(IDX_TIMER_A_COUNT, 32'h2, RESP_OKAY);
      rd(IDX_TIMER_B_COUNT, 32'h8, RESP_OKAY);
      give_verdict();
   end
endmodule : tb_top

/* verilog/dual_reload_timers_watchdog.sv */
// Functional notes
// - 16-bit down counter, two write-only reload bytes
// - Enabled counter decrements once per source pulse
// - Timer A interrupts on 0000 to FFFF
// - Timer A reloads from its bytes on underflow
// - Reload N gives period of N+1 pulses
// - Reset clears counter; first tick underflows
// - Timer A: slow clock, fast in fast-only
// - Timer B ticks at system clock over 1.5
// - Timer B underflows, reloads, period N+1
// - Timer B zero after reset, immediate underflow
// - Enable bit 2 gates timer A interrupt
// - Enable bit 1 gates timer B interrupt
// - Control bit 2 runs timer A
// - Control bit 3 runs timer B
// - Timer A reload bytes at 0x03, 0x04
// - Timer B reload bytes at 0x05, 0x06
// - Watchdog present only when build option set
// - Watchdog resets after 32768 timer A pulses
// - Clear instruction restarts the watchdog count
// - Watchdog counts except in sleep mode
//
// Decided for this implementation: the AXI4-Lite slave port.
`timescale 1ns/10ps
module dual_reload_timers_watchdog
   import timers_pkg::*;
#(
   parameter int WATCHDOG_BUILD_OPTION = 1,
   parameter int WATCHDOG_PULSES = WATCHDOG_PULSES_DEFAULT
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire axil_req_type i_axil,
   output axil_rsp_type o_axil,
   input wire logic i_slow_clock,
   input wire logic i_fast_clock,
   input wire logic i_watchdog_clear_instruction,
   output logic o_timer_a_irq,
   output logic o_timer_b_irq,
   output logic o_watchdog_reset
);

   localparam int WDT_W = $clog2(WATCHDOG_PULSES);
   localparam logic [WDT_W-1:0] WDT_LAST = WDT_W'(WATCHDOG_PULSES - 1);

   if (WATCHDOG_BUILD_OPTION != 0 && WATCHDOG_BUILD_OPTION != 1) begin : g_bad_option
      $error("WATCHDOG_BUILD_OPTION must be 0 or 1");
   end
   if (WATCHDOG_PULSES < 2 || WATCHDOG_PULSES > 65536) begin : g_bad_pulses
      $error("WATCHDOG_PULSES must lie in 2..65536");
   end

   function automatic logic reg_mapped(input logic [ADDR_W-1:0] addr);
      logic [5:0] idx;
      idx = addr[ADDR_W-1:2];
      return addr[1:0] == 2'h0 && ((idx >= IDX_INTERRUPT_ENABLE && idx <= IDX_TIMER_B_RELOAD_HIGH)
         || (idx >= IDX_OPERATING_CONTROL && idx <= IDX_TIMER_B_COUNT));
   endfunction : reg_mapped

   logic [7:0] ier_q;
   logic [7:0] op_q;
   mode_type mode_q;
   logic [7:0] reload_lo_q [2];
   logic [7:0] reload_hi_q [2];
   logic [1:0] pend_q;
   logic [1:0] pin_meta_q;
   logic [1:0] pin_sync_q;
   logic [1:0] pin_last_q;
   logic slow_pulse;
   logic fast_pulse;
   logic tick_a;
   logic fsys_pulse;
   logic tick_b;
   logic [1:0] phase_q;
   logic [1:0] run;
   logic [1:0] ticks;
   logic [1:0] underflow;
   logic [1:0] irq_en;
   logic [1:0] pend_clear;
   logic [TIMER_WIDTH-1:0] count [2];
   logic [WDT_W-1:0] wdt_q;
   logic wdt_reset_q;

   ////////////////////////////////////////////////////////////////////////////
   // Clock pins are asynchronous: two flops, then edge detect on the second
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pin_meta_q <= 2'h0;
         pin_sync_q <= 2'h0;
         pin_last_q <= 2'h0;
      end else begin
         pin_meta_q <= {i_fast_clock, i_slow_clock};
         pin_sync_q <= pin_meta_q;
         pin_last_q <= pin_sync_q;
      end
   end

   assign slow_pulse = pin_sync_q[0] && !pin_last_q[0];
   assign fast_pulse = pin_sync_q[1] && !pin_last_q[1];

   always_comb begin
      tick_a = 1'b0;
      fsys_pulse = 1'b0;
      case (mode_q)
         MODE_FAST: begin
            tick_a = fast_pulse;
            fsys_pulse = fast_pulse;
         end
         MODE_SLOW: begin
            tick_a = slow_pulse;
            fsys_pulse = slow_pulse;
         end
         MODE_IDLE: begin
            tick_a = slow_pulse;
         end
         MODE_SLEEP: begin
            tick_a = 1'b0;
         end
         default: begin
            tick_a = slow_pulse;
            fsys_pulse = fast_pulse;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         phase_q <= 2'h0;
      end else if (fsys_pulse) begin
         phase_q <= (phase_q == DIV_LAST_PHASE) ? 2'h0 : phase_q + 2'h1;
      end
   end

   assign tick_b = fsys_pulse && (phase_q != DIV_LAST_PHASE);

   ////////////////////////////////////////////////////////////////////////////
   // Timers
   // run bits of timers A and B
   assign run = {op_q[TIMER_B_RUN_BIT], op_q[TIMER_A_RUN_BIT]};
   assign ticks = {tick_b, tick_a};
   assign irq_en = {ier_q[TIMER_B_IRQ_ENABLE_BIT], ier_q[TIMER_A_IRQ_ENABLE_BIT]};

   for (genvar t = 0; t < 2; t++) begin : g_timer
      reload_down_counter #(
         .WIDTH(TIMER_WIDTH)
      ) u_counter (
         .i_clk(i_clk),
         .i_resetn(i_resetn),
         .i_run(run[t]),
         .i_tick(ticks[t]),
         .i_reload({reload_hi_q[t], reload_lo_q[t]}),
         .o_count(count[t]),
         .o_underflow(underflow[t])
      );
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         pend_q <= 2'h0;
      end else begin
         pend_q <= (pend_q & ~pend_clear) | (underflow & irq_en);
      end
   end

   assign o_timer_a_irq = pend_q[0];
   assign o_timer_b_irq = pend_q[1];

   ////////////////////////////////////////////////////////////////////////////
   // Watchdog on timer A's source; clear wins over a pulse in the same cycle
   // build option removes watchdog
   if (WATCHDOG_BUILD_OPTION == 1) begin : g_watchdog
      always_ff @(posedge i_clk or negedge i_resetn) begin
         if (!i_resetn) begin
            wdt_q <= '0;
            wdt_reset_q <= 1'b0;
         end else if (i_watchdog_clear_instruction) begin
            wdt_q <= '0;
            wdt_reset_q <= 1'b0;
         end else if (tick_a) begin
            wdt_q <= (wdt_q == WDT_LAST) ? '0 : wdt_q + 1'b1;
            wdt_reset_q <= (wdt_q == WDT_LAST);
         end else begin
            wdt_reset_q <= 1'b0;
         end
      end

      a_wdt_overflow:
         assert property (@(posedge i_clk) disable iff (!i_resetn)
            wdt_reset_q |-> $past(wdt_q) == WDT_LAST && $past(tick_a))
         else $error("watchdog reset without overflow");
      a_wdt_clear:
         assert property (@(posedge i_clk) disable iff (!i_resetn)
            i_watchdog_clear_instruction |=> wdt_q == '0 && !wdt_reset_q)
         else $error("watchdog clear did not restart the count");
      a_wdt_sleep_hold:
         assert property (@(posedge i_clk) disable iff (!i_resetn)
            mode_q == MODE_SLEEP && !i_watchdog_clear_instruction |=> $stable(wdt_q))
         else $error("watchdog counted in sleep");
   end else begin : g_no_watchdog
      assign wdt_q = '0;
      assign wdt_reset_q = 1'b0;
   end

   assign o_watchdog_reset = wdt_reset_q;

   ////////////////////////////////////////////////////////////////////////////
   // Bus write path: address and data held separately, then one write
   logic aw_held_q;
   logic w_held_q;
   logic awready_q;
   logic wready_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic [ADDR_W-1:0] wr_addr_q;
   logic [31:0] wr_data_q;
   logic wr_lane_q;
   logic aw_fire;
   logic w_fire;
   logic wr_do;
   logic wr_en;
   logic [5:0] wr_idx;

   assign aw_fire = i_axil.awvalid && awready_q;
   assign w_fire = i_axil.wvalid && wready_q;
   assign wr_do = aw_held_q && w_held_q && !bvalid_q;
   assign wr_idx = wr_addr_q[ADDR_W-1:2];
   // Registers are one byte wide: only lane 0 writes them
   assign wr_en = wr_do && wr_lane_q && reg_mapped(wr_addr_q);
   assign pend_clear = (wr_en && wr_idx == IDX_IRQ_PENDING) ?
      {wr_data_q[TIMER_B_IRQ_ENABLE_BIT], wr_data_q[TIMER_A_IRQ_ENABLE_BIT]} : 2'h0;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         aw_held_q <= 1'b0;
         awready_q <= 1'b0;
         wr_addr_q <= '0;
      end else if (aw_fire) begin
         aw_held_q <= 1'b1;
         awready_q <= 1'b0;
         wr_addr_q <= i_axil.awaddr;
      end else if (wr_do) begin
         aw_held_q <= 1'b0;
         awready_q <= 1'b1;
      end else if (!aw_held_q) begin
         awready_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         w_held_q <= 1'b0;
         wready_q <= 1'b0;
         wr_data_q <= '0;
         wr_lane_q <= 1'b0;
      end else if (w_fire) begin
         w_held_q <= 1'b1;
         wready_q <= 1'b0;
         wr_data_q <= i_axil.wdata;
         wr_lane_q <= i_axil.wstrb[0];
      end else if (wr_do) begin
         w_held_q <= 1'b0;
         wready_q <= 1'b1;
      end else if (!w_held_q) begin
         wready_q <= 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         bvalid_q <= 1'b0;
         bresp_q <= RESP_OKAY;
      end else if (wr_do) begin
         bvalid_q <= 1'b1;
         bresp_q <= reg_mapped(wr_addr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bvalid_q && i_axil.bready) begin
         bvalid_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ier_q <= INTERRUPT_ENABLE_RESET;
         op_q <= OPERATING_CONTROL_RESET;
         mode_q <= MODE_RESET;
         reload_lo_q <= '{2{8'h00}};
         reload_hi_q <= '{2{8'h00}};
      end else if (wr_en) begin
         if (wr_idx == IDX_INTERRUPT_ENABLE) begin
            ier_q <= wr_data_q[7:0] & 8'h06;
         end else if (wr_idx == IDX_TIMER_A_RELOAD_LOW) begin
            reload_lo_q[0] <= wr_data_q[7:0];
         end else if (wr_idx == IDX_TIMER_A_RELOAD_HIGH) begin
            reload_hi_q[0] <= wr_data_q[7:0];
         end else if (wr_idx == IDX_TIMER_B_RELOAD_LOW) begin
            reload_lo_q[1] <= wr_data_q[7:0];
         end else if (wr_idx == IDX_TIMER_B_RELOAD_HIGH) begin
            reload_hi_q[1] <= wr_data_q[7:0];
         end else if (wr_idx == IDX_OPERATING_CONTROL) begin
            op_q <= wr_data_q[7:0] & 8'h0c;
         end else if (wr_idx == IDX_CLOCK_MODE && wr_data_q[2:0] <= MODE_SLEEP) begin
            mode_q <= mode_type'(wr_data_q[2:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Bus read path: data latched on the address handshake
   logic arready_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;
   logic ar_fire;
   logic [5:0] rd_idx;

   assign ar_fire = i_axil.arvalid && arready_q;
   assign rd_idx = i_axil.araddr[ADDR_W-1:2];

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= RESP_OKAY;
      end else if (ar_fire) begin
         arready_q <= 1'b0;
         rvalid_q <= 1'b1;
         rresp_q <= reg_mapped(i_axil.araddr) ? RESP_OKAY : RESP_SLVERR;
         // Reload bytes are write-only and read as zero
         if (!reg_mapped(i_axil.araddr)) begin
            rdata_q <= '0;
         end else if (rd_idx == IDX_INTERRUPT_ENABLE) begin
            rdata_q <= {24'h0, ier_q};
         end else if (rd_idx == IDX_OPERATING_CONTROL) begin
            rdata_q <= {24'h0, op_q};
         end else if (rd_idx == IDX_IRQ_PENDING) begin
            rdata_q <= {29'h0, pend_q[0], pend_q[1], 1'b0};
         end else if (rd_idx == IDX_CLOCK_MODE) begin
            rdata_q <= {29'h0, mode_q};
         end else if (rd_idx == IDX_TIMER_A_COUNT) begin
            rdata_q <= {16'h0, count[0]};
         end else if (rd_idx == IDX_TIMER_B_COUNT) begin
            rdata_q <= {16'h0, count[1]};
         end else begin
            rdata_q <= '0;
         end
      end else if (rvalid_q && i_axil.rready) begin
         rvalid_q <= 1'b0;
         arready_q <= 1'b1;
      end else if (!rvalid_q) begin
         arready_q <= 1'b1;
      end
   end

   assign o_axil = '{awready: awready_q, wready: wready_q, bvalid: bvalid_q,
      bresp: bresp_q, arready: arready_q, rvalid: rvalid_q, rdata: rdata_q,
      rresp: rresp_q};

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   sequence s_skip_phase;
      fsys_pulse && phase_q == DIV_LAST_PHASE;
   endsequence
   sequence s_write_ready;
      aw_held_q && w_held_q && !bvalid_q;
   endsequence

   a_pend_gate_a:
      assert property ($rose(pend_q[0]) |-> $past(underflow[0] && irq_en[0]))
      else $error("timer A pending without enabled underflow");
   a_pend_gate_b:
      assert property ($rose(pend_q[1]) |-> $past(underflow[1] && irq_en[1]))
      else $error("timer B pending without enabled underflow");
   a_pend_set_wins:
      assert property (underflow[0] && irq_en[0] |=> pend_q[0] && o_timer_a_irq)
      else $error("enabled underflow lost");
   a_run_a_stop:
      assert property (!run[0] |=> count[0] == $past(count[0]))
      else $error("timer A moved while stopped");
   a_run_b_stop:
      assert property (!run[1] |=> count[1] == $past(count[1]))
      else $error("timer B moved while stopped");
   a_div_skip:
      assert property (s_skip_phase |-> !tick_b ##1 phase_q == 2'h0)
      else $error("divider did not skip the third pulse");
   a_src_fast:
      assert property (mode_q == MODE_FAST |-> tick_a == fast_pulse)
      else $error("timer A not on fast clock in fast mode");
   a_write_resp:
      assert property (s_write_ready |=> bvalid_q && awready_q && wready_q)
      else $error("write response missing");

endmodule : dual_reload_timers_watchdog

/* verilog/reload_down_counter.sv */
`timescale 1ns/10ps
module reload_down_counter #(
   parameter int WIDTH = 16
) (
   input wire logic i_clk,
   input wire logic i_resetn,
   input wire logic i_run,
   input wire logic i_tick,
   input wire logic [WIDTH-1:0] i_reload,
   output logic [WIDTH-1:0] o_count,
   output logic o_underflow
);

   if (WIDTH < 2) begin : g_bad_width
      $error("reload_down_counter: WIDTH must be at least 2");
   end

   logic [WIDTH-1:0] count_q;
   logic underflow_q;
   logic step;

   assign step = i_run && i_tick;

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         count_q <= '0;
      end else if (step) begin
         count_q <= (count_q == '0) ? i_reload : count_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         underflow_q <= 1'b0;
      end else begin
         underflow_q <= step && (count_q == '0);
      end
   end

   assign o_count = count_q;
   assign o_underflow = underflow_q;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);

   a_count_step_down:
      assert property (step && count_q != '0 |=> count_q == $past(count_q) - 1'b1)
      else $error("counter did not step down by one");
   a_underflow_cause:
      assert property (underflow_q |-> $past(step) && $past(count_q) == '0)
      else $error("underflow without a tick at zero");
   a_reload_value:
      assert property (step && count_q == '0 |=> underflow_q && count_q == $past(i_reload))
      else $error("counter not reloaded on underflow");
   a_idle_hold:
      assert property (!step |=> count_q == $past(count_q) && !underflow_q)
      else $error("counter moved without a tick");

endmodule : reload_down_counter

/* verilog/timers_pkg.sv */
package timers_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Register map: printed offsets are word indices, byte address = 4 * index
   localparam int ADDR_W = 8;
   localparam logic [5:0] IDX_INTERRUPT_ENABLE = 6'h02;
   localparam logic [5:0] IDX_TIMER_A_RELOAD_LOW = 6'h03;
   localparam logic [5:0] IDX_TIMER_A_RELOAD_HIGH = 6'h04;
   localparam logic [5:0] IDX_TIMER_B_RELOAD_LOW = 6'h05;
   localparam logic [5:0] IDX_TIMER_B_RELOAD_HIGH = 6'h06;
   localparam logic [5:0] IDX_OPERATING_CONTROL = 6'h09;
   localparam logic [5:0] IDX_IRQ_PENDING = 6'h0a;
   localparam logic [5:0] IDX_CLOCK_MODE = 6'h0b;
   localparam logic [5:0] IDX_TIMER_A_COUNT = 6'h0c;
   localparam logic [5:0] IDX_TIMER_B_COUNT = 6'h0d;

   ////////////////////////////////////////////////////////////////////////////
   // Field positions and reset values
   localparam int TIMER_A_IRQ_ENABLE_BIT = 2;
   localparam int TIMER_B_IRQ_ENABLE_BIT = 1;
   localparam int TIMER_A_RUN_BIT = 2;
   localparam int TIMER_B_RUN_BIT = 3;
   localparam logic [7:0] INTERRUPT_ENABLE_RESET = 8'h00;
   localparam logic [7:0] OPERATING_CONTROL_RESET = 8'h00;
   localparam int TIMER_WIDTH = 16;
   localparam int WATCHDOG_PULSES_DEFAULT = 32768;
   // Divide by 1.5: two ticks out of every three system clock pulses
   localparam logic [1:0] DIV_LAST_PHASE = 2'h2;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [2:0] {
      MODE_DUAL = 3'b000,
      MODE_FAST = 3'b001,
      MODE_SLOW = 3'b010,
      MODE_IDLE = 3'b011,
      MODE_SLEEP = 3'b100
   } mode_type;
   localparam mode_type MODE_RESET = MODE_DUAL;

   typedef struct packed {
      logic awvalid;
      logic [ADDR_W-1:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [ADDR_W-1:0] araddr;
      logic rready;
   } axil_req_type;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } axil_rsp_type;

endpackage : timers_pkg
